// [include/ptpa_regs.vh]
// constants for the pulse train positioning axis
`ifndef PTPA_REGS_VH
`define PTPA_REGS_VH
`define PTPA_FREQ_W 24
`define PTPA_CNT_W 32
`define PTPA_PHASE_W 32
`define PTPA_FIFO_DEPTH 4
`define PTPA_FIFO_AW 2
`define PTPA_POS_SCALE_SH 2
`define PTPA_CLK_HZ 25000000
`define PTPA_RAMP_TICK_NS 40000
`define PTPA_CLK_NS 40
`define PTPA_RAMP_TICK_CYC ((`PTPA_RAMP_TICK_NS + `PTPA_CLK_NS - 1) / `PTPA_CLK_NS)
`define PTPA_ST_IDLE 3'h0
`define PTPA_ST_LOAD 3'h1
`define PTPA_ST_ACC 3'h2
`define PTPA_ST_RUN 3'h3
`define PTPA_ST_DEC 3'h4
`define PTPA_ST_DONE 3'h5
`endif

// [rtl/ptpa_sync2.v]
// two-flop synchroniser for a bus of asynchronous pin levels
`timescale 1ns/1ns
`default_nettype none
module ptpa_sync2 #(
  parameter W = 1 // number of lines
) (
  input wire mclk_in,
  input wire arst_n_in,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_q; // first stage, read only by stage two
  reg [W-1:0] sync_q; // second stage
  // plain double register, constants under reset
  always @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule // ptpa_sync2
`default_nettype wire

// [rtl/ptpa_axis.v]
// one pulse train positioning axis with trapezoidal profile and entry queue
//
// Overview of operation
// - start pulses at software start frequency
// - linear rise, constant section, linear fall
// - compute deceleration point from remaining pulses
// - accept new target frequency while moving
// - add extra pulses to current move
// - stop request decelerates with selectable rate
// - emergency stop halts pulses quickly
// - overtravel decelerates and stops the axis
// - program or transmission error quick-stops axis
// - count pulses on external pulse input
// - four-entry queue executed in order
// - accept queue pushes while not full
// - accept entries during frequency change
// - report all digital input line states
// - drive digital outputs as commanded
// - separate forward and reverse pulse lines
// - command position counts four per pulse
// - latch position on chosen phase Z edge
`timescale 1ns/1ns
`default_nettype none
`include "ptpa_regs.vh"
module ptpa_axis #(
  parameter FW = `PTPA_FREQ_W, // frequency word width, Hz
  parameter CW = `PTPA_CNT_W, // pulse count width
  parameter DEPTH = `PTPA_FIFO_DEPTH, // queue entries
  parameter AW = `PTPA_FIFO_AW, // queue pointer width
  parameter DIW = 8, // digital input lines
  parameter DOW = 8, // digital output lines
  parameter RAMP_TICK_CYC = `PTPA_RAMP_TICK_CYC // cycles per ramp step
) (
  input wire mclk_in,
  input wire arst_n_in,
  input wire [FW-1:0] start_freq_in,
  input wire [FW-1:0] accel_step_in,
  input wire [FW-1:0] decel_step_a_in,
  input wire [FW-1:0] decel_step_b_in,
  input wire decel_sel_in,
  input wire push_in,
  input wire [CW-1:0] push_count_in,
  input wire [FW-1:0] push_freq_in,
  input wire push_dir_in,
  input wire freq_wr_in,
  input wire [FW-1:0] freq_new_in,
  input wire add_wr_in,
  input wire [CW-1:0] add_count_in,
  input wire stop_req_in,
  input wire emergency_in,
  input wire overtravel_limit_fwd_in,
  input wire overtravel_limit_rev_in,
  input wire prog_fail_in,
  input wire xfer_err_in,
  input wire ext_pulse_in,
  input wire home_limit_switch_in,
  input wire phase_z_in,
  input wire z_edge_fall_in,
  input wire [DIW-1:0] digital_input_line_in,
  input wire [DOW-1:0] do_cmd_in,
  output reg forward_pulse_line_out,
  output reg reverse_pulse_line_out,
  output reg [DOW-1:0] do_out,
  output reg [DIW+1:0] di_state_out,
  output reg [CW-1:0] cmd_pos_out,
  output reg [CW-1:0] z_pos_out,
  output reg z_latched_out,
  output reg [CW-1:0] ext_count_out,
  output reg queue_full_out,
  output reg [AW:0] queue_level_out,
  output reg busy_out,
  output reg done_out,
  output reg fault_out
);
  // pin inputs synchronised
  localparam SW = DIW + 9;
  wire [SW-1:0] pins_s;
  ptpa_sync2 #(.W(SW)) u_sync (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .async_in({digital_input_line_in, emergency_in, overtravel_limit_fwd_in,
      overtravel_limit_rev_in, prog_fail_in, xfer_err_in, ext_pulse_in,
      home_limit_switch_in, phase_z_in, stop_req_in}),
    .sync_out(pins_s)
  );
  wire [DIW-1:0] di_s = pins_s[SW-1:9];
  wire emg_s = pins_s[8];
  wire otf_s = pins_s[7];
  wire otr_s = pins_s[6];
  wire quick_s = pins_s[5] | pins_s[4] | emg_s; // quick stop causes
  wire ext_s = pins_s[3];
  wire home_s = pins_s[2];
  wire z_s = pins_s[1];
  wire stop_s = pins_s[0];

  // queue storage, entry = {dir, freq, count}
  localparam EW = CW + FW + 1;
  reg [EW-1:0] fifo_mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] level_q;
  wire fifo_full = (level_q == DEPTH);
  wire fifo_empty = (level_q == {(AW+1){1'b0}});
  wire do_push = push_in & ~fifo_full;
  reg do_pop; // set by the sequencer
  wire [EW-1:0] head = fifo_mem[rd_ptr_q];

  // queue write and pointers; push accepted in every state
  always @(posedge mclk_in)
  begin
    if (do_push)
      fifo_mem[wr_ptr_q] <= {push_dir_in, push_freq_in, push_count_in};
  end
  always @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      level_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_push)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (do_pop)
        rd_ptr_q <= rd_ptr_q + 1'b1;
      // simultaneous push and pop leaves level unchanged
      if (do_push & ~do_pop)
        level_q <= level_q + 1'b1;
      else if (do_pop & ~do_push)
        level_q <= level_q - 1'b1;
    end
  end

  // motion state
  reg [2:0] st_q;
  reg [FW-1:0] freq_q; // present output frequency
  reg [FW-1:0] tgt_q; // target frequency
  reg [CW-1:0] remain_q; // pulses still to emit
  reg [CW-1:0] decel_pulses_q; // pulses spent during ramp up so far
  reg dir_q; // 1 = reverse
  reg [15:0] tick_q; // ramp step timer
  reg [`PTPA_PHASE_W-1:0] phase_q; // pulse accumulator
  reg half_q; // pulse high half
  reg stopping_q; // stop or overtravel forced ramp down
  wire [FW-1:0] dstep = decel_sel_in ? decel_step_b_in : decel_step_a_in;
  wire tick = (tick_q == RAMP_TICK_CYC - 1);
  // phase accumulator wraps at half the clock rate, two wraps per pulse
  wire [`PTPA_PHASE_W:0] phase_sum = {1'b0, phase_q} + {{(`PTPA_PHASE_W+1-FW){1'b0}}, freq_q};
  wire wrap = (phase_sum >= `PTPA_CLK_HZ / 2);
  wire moving = (st_q == `PTPA_ST_ACC) | (st_q == `PTPA_ST_RUN) | (st_q == `PTPA_ST_DEC);
  wire pulse_end = moving & wrap & half_q; // falling edge of one pulse
  // decel point: remaining pulses at most one more than those used to ramp up
  wire at_decel_pt = (remain_q <= decel_pulses_q + 1'b1);
  wire ot_hit = dir_q ? otr_s : otf_s;
  // pulses left after this one, plus any added count
  wire [CW-1:0] remain_nx = remain_q - (pulse_end ? 1'b1 : 1'b0)
    + (add_wr_in ? add_count_in : {CW{1'b0}});

  always @*
  begin
    do_pop = (st_q == `PTPA_ST_LOAD);
  end

  // sequencer
  always @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_q <= `PTPA_ST_IDLE;
      freq_q <= {FW{1'b0}};
      tgt_q <= {FW{1'b0}};
      remain_q <= {CW{1'b0}};
      decel_pulses_q <= {CW{1'b0}};
      dir_q <= 1'b0;
      tick_q <= 16'h0000;
      phase_q <= {`PTPA_PHASE_W{1'b0}};
      half_q <= 1'b0;
      stopping_q <= 1'b0;
      fault_out <= 1'b0;
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      tick_q <= tick ? 16'h0000 : tick_q + 16'h0001;
      if (moving)
      begin
        phase_q <= wrap ? phase_sum[`PTPA_PHASE_W-1:0] - `PTPA_CLK_HZ / 2
          : phase_sum[`PTPA_PHASE_W-1:0];
        if (wrap)
          half_q <= ~half_q;
        remain_q <= remain_nx;
        if (freq_wr_in)
          tgt_q <= freq_new_in;
        if (stop_s | ot_hit)
          stopping_q <= 1'b1;
      end
      if (moving & quick_s)
      begin
        // quick stop: cut the train at once
        st_q <= `PTPA_ST_IDLE;
        freq_q <= {FW{1'b0}};
        half_q <= 1'b0;
        remain_q <= {CW{1'b0}};
        fault_out <= 1'b1;
      end
      else
      begin
        case (st_q)
          `PTPA_ST_IDLE:
          begin
            stopping_q <= 1'b0;
            if (!fifo_empty & !quick_s)
            begin
              st_q <= `PTPA_ST_LOAD;
              fault_out <= 1'b0;
            end
          end
          `PTPA_ST_LOAD:
          begin
            // take head entry, begin at start frequency
            remain_q <= head[CW-1:0];
            tgt_q <= head[CW+FW-1:CW];
            dir_q <= head[EW-1];
            freq_q <= start_freq_in;
            decel_pulses_q <= {CW{1'b0}};
            phase_q <= {`PTPA_PHASE_W{1'b0}};
            half_q <= 1'b0;
            st_q <= (head[CW-1:0] == {CW{1'b0}}) ? `PTPA_ST_DONE : `PTPA_ST_ACC;
          end
          `PTPA_ST_ACC:
          begin
            // linear rise
            if (pulse_end)
              decel_pulses_q <= decel_pulses_q + 1'b1;
            if (stopping_q | at_decel_pt)
              st_q <= `PTPA_ST_DEC;
            else if (freq_q >= tgt_q)
            begin
              freq_q <= tgt_q;
              st_q <= `PTPA_ST_RUN;
            end
            else if (tick)
              freq_q <= (tgt_q - freq_q > accel_step_in) ? freq_q + accel_step_in : tgt_q;
          end
          `PTPA_ST_RUN:
          begin
            // constant section, follow retargets
            if (stopping_q | at_decel_pt)
              st_q <= `PTPA_ST_DEC;
            else if (freq_q != tgt_q)
              st_q <= `PTPA_ST_ACC;
          end
          `PTPA_ST_DEC:
          begin
            // linear fall toward start frequency
            if (pulse_end & decel_pulses_q != {CW{1'b0}})
              decel_pulses_q <= decel_pulses_q - 1'b1;
            if (tick & freq_q > start_freq_in)
              freq_q <= (freq_q - start_freq_in > dstep) ? freq_q - dstep : start_freq_in;
            if (remain_nx == {CW{1'b0}} | (stopping_q & freq_q <= start_freq_in & pulse_end))
              st_q <= `PTPA_ST_DONE;
            else if (!stopping_q & !at_decel_pt & freq_q < tgt_q)
              st_q <= `PTPA_ST_ACC; // more pulses added
          end
          `PTPA_ST_DONE:
          begin
            freq_q <= {FW{1'b0}};
            half_q <= 1'b0;
            // chain next entry unless stopped
            if (!fifo_empty & !stopping_q)
              st_q <= `PTPA_ST_LOAD;
            else
            begin
              st_q <= `PTPA_ST_IDLE;
              done_out <= ~stopping_q;
            end
          end
          default:
            st_q <= `PTPA_ST_IDLE;
        endcase
      end
    end
  end

  // pulse lines, position, z latch, counters and pins
  reg z_prev_q;
  reg ext_prev_q;
  wire z_edge = z_edge_fall_in ? (z_prev_q & ~z_s) : (~z_prev_q & z_s);
  always @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      forward_pulse_line_out <= 1'b0;
      reverse_pulse_line_out <= 1'b0;
      cmd_pos_out <= {CW{1'b0}};
      z_pos_out <= {CW{1'b0}};
      z_latched_out <= 1'b0;
      ext_count_out <= {CW{1'b0}};
      z_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
      do_out <= {DOW{1'b0}};
      di_state_out <= {(DIW+2){1'b0}};
      queue_full_out <= 1'b0;
      queue_level_out <= {(AW+1){1'b0}};
      busy_out <= 1'b0;
    end
    else
    begin
      forward_pulse_line_out <= moving & half_q & ~dir_q & ~quick_s;
      reverse_pulse_line_out <= moving & half_q & dir_q & ~quick_s;
      if (pulse_end & ~quick_s)
        cmd_pos_out <= dir_q ? cmd_pos_out - (1'b1 << `PTPA_POS_SCALE_SH)
          : cmd_pos_out + (1'b1 << `PTPA_POS_SCALE_SH);
      z_prev_q <= z_s;
      if (z_edge)
      begin
        z_pos_out <= cmd_pos_out;
        z_latched_out <= 1'b1;
      end
      ext_prev_q <= ext_s;
      if (ext_s & ~ext_prev_q)
        ext_count_out <= ext_count_out + 1'b1;
      do_out <= do_cmd_in;
      di_state_out <= {di_s, z_s, home_s};
      queue_full_out <= fifo_full;
      queue_level_out <= level_q;
      busy_out <= (st_q != `PTPA_ST_IDLE);
    end
  end
endmodule // ptpa_axis
`default_nettype wire

// [verification/ptpa_axis_assertions.sv]
// assertion checker bound to the positioning axis ports
`timescale 1ns/1ns
`default_nettype none
module ptpa_axis_chk #(
  parameter CW = 32,
  parameter DOW = 8,
  parameter AW = 2
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic [DOW-1:0] do_cmd_in,
  input wire logic emergency_in,
  input wire logic prog_fail_in,
  input wire logic xfer_err_in,
  input wire logic forward_pulse_line_out,
  input wire logic reverse_pulse_line_out,
  input wire logic [DOW-1:0] do_out,
  input wire logic [CW-1:0] cmd_pos_out,
  input wire logic [CW-1:0] ext_count_out,
  input wire logic queue_full_out,
  input wire logic [AW:0] queue_level_out,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic fault_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  logic [1:0] live_q; // edges since reset, saturating
  // past values are only trusted once reset lies three edges back
  always @(posedge mclk_in or negedge arst_n_in)
    if (!arst_n_in)
      live_q <= 2'h0;
    else if (live_q != 2'h3)
      live_q <= live_q + 2'h1;
  // quick stop: cut and flagged within a few cycles
  sequence s_cut;
    ##[1:6] (fault_out && !busy_out);
  endsequence
  // done stands one cycle with the queue empty
  sequence s_done;
    queue_level_out == 3'h0 ##1 !done_out;
  endsequence
  property p_lines; !(forward_pulse_line_out && reverse_pulse_line_out); endproperty
  a_lines: assert property (p_lines) else $error("both pulse lines high");
  property p_step;
    live_q == 2'h3 && cmd_pos_out != $past(cmd_pos_out) |->
      cmd_pos_out - $past(cmd_pos_out) == 32'h4 || $past(cmd_pos_out) - cmd_pos_out == 32'h4;
  endproperty
  a_step: assert property (p_step) else $error("position step not four");
  property p_full; queue_full_out == (queue_level_out == 3'h4); endproperty
  a_full: assert property (p_full) else $error("full flag disagrees with level");
  property p_level; queue_level_out <= 3'h4; endproperty
  a_level: assert property (p_level) else $error("queue level above four");
  property p_do; live_q == 2'h3 |-> do_out == $past(do_cmd_in); endproperty
  a_do: assert property (p_do) else $error("digital outputs not following");
  property p_done; done_out |-> s_done; endproperty
  a_done: assert property (p_done) else $error("done pulse malformed");
  property p_emg; emergency_in && busy_out |-> s_cut; endproperty
  a_emg: assert property (p_emg) else $error("emergency did not cut");
  property p_err; (prog_fail_in || xfer_err_in) && busy_out |-> s_cut; endproperty
  a_err: assert property (p_err) else $error("bus error did not cut");
  property p_ext;
    live_q == 2'h3 && ext_count_out != $past(ext_count_out) |->
      ext_count_out == $past(ext_count_out) + 32'h1;
  endproperty
  a_ext: assert property (p_ext) else $error("external count jumped");
endmodule // ptpa_axis_chk
bind ptpa_axis ptpa_axis_chk #(.CW(CW), .DOW(DOW), .AW(AW)) chk (.*);
`default_nettype wire

// [verification/ptpa_cpu_model.sv]
// cpu side model feeding entries and live changes
`timescale 1ns/1ns
`default_nettype none
module ptpa_cpu_model (
  input wire logic mclk_in,
  input wire logic queue_full_in,
  output logic push_out,
  output logic [31:0] count_out,
  output logic [23:0] freq_out,
  output logic dir_out,
  output logic freq_wr_out,
  output logic add_wr_out
);
  initial
  begin
    push_out = 1'b0;
    freq_wr_out = 1'b0;
    add_wr_out = 1'b0;
    count_out = 32'h0;
    freq_out = 24'h0;
    dir_out = 1'b0;
  end
  // one request, k = {push, freq, add}, held up to its taking edge
  task req(input [2:0] k, input [31:0] c, input [23:0] f, input d);
  begin
    @(negedge mclk_in);
    while (k[2] && queue_full_in === 1'b1) @(negedge mclk_in);
    push_out = k[2];
    freq_wr_out = k[1];
    add_wr_out = k[0];
    count_out = c;
    freq_out = f;
    dir_out = d;
    @(posedge mclk_in);
  end
  endtask
  // release: data inverted so nothing stale looks valid
  task idle;
  begin
    @(negedge mclk_in);
    push_out = 1'b0;
    freq_wr_out = 1'b0;
    add_wr_out = 1'b0;
    count_out = ~count_out;
    freq_out = ~freq_out;
  end
  endtask
endmodule // ptpa_cpu_model
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for the positioning axis
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic mclk = 1'b0; // 25 MHz
  logic arst_n = 1'b0; // reset, active low
  logic sel = 1'b0, stp = 1'b0, emg = 1'b0, otf = 1'b0, otr = 1'b0;
  logic pf = 1'b0, xe = 1'b0, ext = 1'b0, home = 1'b0, z = 1'b0;
  logic [7:0] di = 8'h00, dcmd = 8'h00; // pin levels, output command
  logic fq = 1'b0, rq = 1'b0; // last pulse line levels
  logic zf = 1'b0; // phase z edge select, 1 = falling
  wire push, dir, fwr, awr, full, busy, done, fault, fwd, rev, zl;
  wire [31:0] cnt, pos, ecnt, zpos;
  wire [23:0] frq;
  wire [7:0] dout;
  wire [9:0] dis;
  wire [2:0] lvl;
  integer num_errors = 0, n_compared = 0, npl = 0, nf = 0, dn = 0;
  integer gap = 0, lg = 0, mg = 0; // cycles between pulse starts: running, last, least
  initial forever #20 mclk = ~mclk;
  ptpa_cpu_model cpu (.mclk_in(mclk), .queue_full_in(full), .push_out(push), .count_out(cnt),
    .freq_out(frq), .dir_out(dir), .freq_wr_out(fwr), .add_wr_out(awr));
  // short ramp tick keeps runs brief
  ptpa_axis #(.RAMP_TICK_CYC(2)) uut (.mclk_in(mclk), .arst_n_in(arst_n),
    .start_freq_in(24'h0F4240), .accel_step_in(24'h03D090), .decel_step_a_in(24'h03D090),
    .decel_step_b_in(24'h07A120), .decel_sel_in(sel), .push_in(push), .push_count_in(cnt),
    .push_freq_in(frq), .push_dir_in(dir), .freq_wr_in(fwr), .freq_new_in(frq),
    .add_wr_in(awr), .add_count_in(cnt), .stop_req_in(stp), .emergency_in(emg),
    .overtravel_limit_fwd_in(otf), .overtravel_limit_rev_in(otr), .prog_fail_in(pf),
    .xfer_err_in(xe), .ext_pulse_in(ext), .home_limit_switch_in(home), .phase_z_in(z),
    .z_edge_fall_in(zf), .digital_input_line_in(di), .do_cmd_in(dcmd),
    .forward_pulse_line_out(fwd), .reverse_pulse_line_out(rev), .do_out(dout),
    .di_state_out(dis), .cmd_pos_out(pos), .z_pos_out(zpos), .z_latched_out(zl),
    .ext_count_out(ecnt), .queue_full_out(full), .queue_level_out(lvl), .busy_out(busy),
    .done_out(done), .fault_out(fault));
  // count pulse rising edges and done pulses, and time the pulse spacing
  always @(posedge mclk)
  begin
    fq <= fwd;
    rq <= rev;
    npl = npl + (fwd & !fq) + (rev & !rq);
    nf = nf + (fwd & !fq);
    dn = dn + done;
    gap = gap + 1;
    // a new pulse on either line closes one spacing
    if ((fwd & !fq) | (rev & !rq))
    begin
      if (gap < mg)
        mg = gap;
      lg = gap;
      gap = 0;
    end
  end
  task conclude;
  begin
    if (num_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
  begin
    n_compared = n_compared + 1;
    if (g !== e)
    begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge mclk);
  endtask
  task clr;
  begin
    @(negedge mclk);
    npl = 0;
    nf = 0;
    dn = 0;
    mg = 1000;
  end
  endtask
  // bounded waits: for done, or for busy to drop
  task wdone;
    integer i;
    for (i = 0; i < 30000 && dn == 0; i = i + 1) @(negedge mclk);
  endtask
  task widle(input integer n);
    integer i;
    for (i = 0; i < n && busy !== 1'b0; i = i + 1) @(negedge mclk);
  endtask
  task t_io;
  begin
    dcmd = 8'hA5;
    di = 8'h3C;
    z = 1'b1;
    cyc(6);
    chk("do", 32'hA5, dout);
    chk("di", 32'hF2, dis);
    chk("z latched", 32'h1, zl);
    home = 1'b1;
    repeat (5)
    begin
      ext = 1'b1;
      cyc(3);
      ext = 1'b0;
      cyc(3);
    end
    chk("ext count", 32'h5, ecnt);
    chk("di home", 32'hF3, dis);
  end
  endtask
  task t_move;
    integer d;
    logic [31:0] p0;
    for (d = 0; d < 2; d = d + 1)
    begin
      clr;
      p0 = pos;
      cpu.req(3'h4, 32'hA, 24'h1E8480, d[0]);
      cpu.idle;
      wdone;
      cyc(4);
      chk("pulses", 32'hA, npl);
      chk("done", 32'h1, dn);
      chk("one line", 32'h0, nf * (npl - nf));
      chk("pos step", d ? 32'hFFFFFFD8 : 32'h28, pos - p0);
      chk("fwd pulses", d ? 32'h0 : 32'hA, nf);
      chk("min gap", 32'hC, mg);
      // falling edge latches the forward end; a later rising edge is ignored
      if (d == 0)
      begin
        zf = 1'b1;
        z = 1'b0;
      end
      else
        z = 1'b1;
      cyc(4);
      chk("z pos", 32'h28, zpos);
    end
  endtask
  task t_queue;
    integer k;
  begin
    clr;
    for (k = 3; k < 8; k = k + 1)
      cpu.req(3'h4, k, 24'h1E8480, 1'b0);
    cpu.idle;
    cyc(2);
    chk("full", 32'h1, full);
    chk("level", 32'h4, lvl);
    wdone;
    cyc(4);
    chk("queued pulses", 32'h19, npl);
    chk("done", 32'h1, dn);
  end
  endtask
  task t_live;
  begin
    clr;
    cpu.req(3'h4, 32'h14, 24'h0F4240, 1'b0);
    cpu.idle;
    cyc(60);
    // target equals start frequency: 25 cycles per pulse at 1 MHz
    chk("start period", 32'h19, lg);
    cpu.req(3'h1, 32'h7, 24'h0, 1'b0);
    cpu.req(3'h2, 32'h0, 24'h1E8480, 1'b0);
    cpu.req(3'h4, 32'h3, 24'h1E8480, 1'b0);
    cpu.idle;
    wdone;
    cyc(4);
    chk("live pulses", 32'h1E, npl);
  end
  endtask
  task t_stop;
    integer k;
    for (k = 0; k < 3; k = k + 1)
    begin
      clr;
      cpu.req(3'h4, 32'hC8, 24'h1E8480, k[0]);
      cpu.idle;
      cyc(100);
      sel = k[0];
      stp = k < 2;
      otf = k == 2;
      otr = k == 2;
      widle(3000);
      chk("stopped early", 32'h1, npl < 200);
      chk("no fault", 32'h0, fault);
      stp = 1'b0;
      otf = 1'b0;
      otr = 1'b0;
    end
  endtask
  task t_cut;
    integer k, n;
    for (k = 0; k < 3; k = k + 1)
    begin
      clr;
      cpu.req(3'h4, 32'hC8, 24'h1E8480, 1'b1);
      cpu.idle;
      cyc(60);
      emg = k == 0;
      pf = k == 1;
      xe = k == 2;
      widle(8);
      n = npl;
      cyc(50);
      chk("pulses after cut", n, npl);
      chk("fault", 32'h1, fault);
      chk("busy", 32'h0, busy);
      emg = 1'b0;
      pf = 1'b0;
      xe = 1'b0;
    end
  endtask
  initial
  begin
    repeat (6) @(negedge mclk);
    arst_n = 1'b1;
    t_io;
    t_move;
    t_queue;
    t_live;
    t_stop;
    t_cut;
    conclude;
  end
  // hang guard, well past the expected run
  initial
  begin
    #3600000;
    num_errors = num_errors + 1;
    conclude;
  end
endmodule // testbench
`default_nettype wire
